// >>> hdl/i2c_status_pkg.sv
package i2c_status_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] STAT_OFS = 5'h04;
    localparam logic [4:0] TXB_OFS = 5'h08;
    localparam logic [4:0] RXB_OFS = 5'h0c;
    localparam logic [4:0] OWNA_OFS = 5'h10;
    localparam logic [4:0] IRQS_OFS = 5'h14;
    localparam logic [4:0] IRQM_OFS = 5'h18;
    // Status word bit positions
    localparam int ACK_BIT = 15;
    localparam int TRS_BIT = 14;
    localparam int BCL_BIT = 10;
    localparam int GC_BIT = 9;
    localparam int A10_BIT = 8;
    localparam int IWC_BIT = 7;
    localparam int OV_BIT = 6;
    localparam int DA_BIT = 5;
    localparam int P_BIT = 4;
    localparam int S_BIT = 3;
    localparam int RW_BIT = 2;
    localparam int RBF_BIT = 1;
    localparam int TBF_BIT = 0;
    // Control bits
    localparam int ON_BIT = 0;
    localparam int MST_BIT = 1;
    localparam int TEN_BIT = 2;
    // Interrupt event bits
    localparam int EV_RX = 0;
    localparam int EV_TXDONE = 1;
    localparam int EV_BCL = 2;
    localparam int EV_STOP = 3;
    localparam int EV_W = 4;
    // Addresses and counts
    localparam logic [7:0] GENCALL_ADDR = 8'h00;
    localparam logic [4:0] TEN_HDR = 5'h1e;
    localparam logic [3:0] ACK_CNT = 4'h8;
    localparam logic [3:0] LAST_BIT_CNT = 4'h7;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [9:0] OWNA_RST = 10'h000;
    typedef enum {SL_IDLE, SL_ADDR, SL_ADDR2, SL_DATA} slv_t;
endpackage : i2c_status_pkg

// >>> hdl/i2c_status_flags.sv
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module i2c_status_flags
    import i2c_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] ctrl;
    logic [9:0] ownAddr;
    logic [7:0] txBuf, rxBuf, rxShift, txShift;
    logic [EV_W-1:0] irqStat, irqMask;
    logic ack, trs, bus_collision_flag, gc, a10, iwc, ov, da, pFlag, sFlag, rw, rx_buffer_full, tx_buffer_full;
    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
    logic [3:0] bitCnt;
    logic ackPhase, ackSample, ackReq, sdaLow, rdDone;
    slv_t slvState;
    logic [31:0] statusWord, readMux;

    // Two-flop synchronisers, then a third stage purely for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {sclMeta, sclSync, sclPrev} <= 3'h7;
            {sdaMeta, sdaSync, sdaPrev} <= 3'h7;
        end
        else
        begin
            {sclMeta, sclSync, sclPrev} <= {sclIn, sclMeta, sclSync};
            {sdaMeta, sdaSync, sdaPrev} <= {sdaIn, sdaMeta, sdaSync};
        end
    end

    // Bus events and decodes
    wire on = ctrl[ON_BIT];
    wire sclRise = sclSync & ~sclPrev;
    wire sclFall = ~sclSync & sclPrev;
    wire startDet = on & sclSync & sclPrev & sdaPrev & ~sdaSync;
    wire stopDet = on & sclSync & sclPrev & ~sdaPrev & sdaSync;
    wire byteDone = on & sclRise & (bitCnt == LAST_BIT_CNT);
    wire [7:0] byteIn = {rxShift[6:0], sdaSync};
    wire ackEnd = on & sclFall & ackPhase;
    wire mStart = on & ctrl[MST_BIT] & sclFall & (bitCnt == 4'h0) & tx_buffer_full & ~trs & ~bus_collision_flag & ~ackPhase;
    wire collide = trs & sclRise & (bitCnt < ACK_CNT) & ~sdaLow & ~sdaSync;
    wire busy = tx_buffer_full | trs;
    wire slvRx = ~trs & (slvState == SL_DATA) & ~rw;
    wire isGc = byteIn == GENCALL_ADDR;
    wire hdrMatch = ctrl[TEN_BIT] & (byteIn[7:3] == TEN_HDR) & (byteIn[2:1] == ownAddr[9:8]);
    wire match7 = ~ctrl[TEN_BIT] & (byteIn[7:1] == ownAddr[6:0]);
    wire match10 = byteIn == ownAddr[7:0];
    wire addrHit = (slvState == SL_ADDR) & (isGc | match7);
    wire tenHit = (slvState == SL_ADDR2) & match10;

    // Bus-side decodes of the register interface
    wire acc = write | (read & rdDone);
    wire wrCtrl = write & (address == CTRL_OFS);
    wire wrStat = write & (address == STAT_OFS);
    wire wrTx = write & (address == TXB_OFS);
    wire wrOwn = write & (address == OWNA_OFS);
    wire wrIrqS = write & (address == IRQS_OFS);
    wire wrIrqM = write & (address == IRQM_OFS);
    wire rdRx = acc & read & (address == RXB_OFS);
    wire [EV_W-1:0] events = {stopDet, collide, ackEnd & trs, byteDone & slvRx & ~rx_buffer_full};

    ////////////////////////////////////////////////////////////////////////////
    // Bit counter and acknowledge slot tracking
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bitCnt <= 4'h0;
            rxShift <= 8'h00;
            ackPhase <= 1'b0;
            ackSample <= 1'b1;
        end
        else if (~on | startDet | stopDet)
        begin
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
        end
        else if (sclRise)
        begin
            rxShift <= byteIn;
            bitCnt <= (bitCnt == ACK_CNT) ? 4'h0 : bitCnt + 4'h1;
            if (bitCnt == ACK_CNT)
            begin
                ackPhase <= 1'b1;
                ackSample <= sdaSync;
            end
        end
        else if (sclFall)
            ackPhase <= 1'b0;
    end

    // Master byte sending and the open-drain pull on SDA
    // SDA only moves on SCL falls, so our own data never looks like start or stop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txShift <= 8'h00;
            sdaLow <= 1'b0;
        end
        else if (~on | stopDet | collide)
            sdaLow <= 1'b0;
        else if (mStart)
        begin
            txShift <= txBuf;
            sdaLow <= ~txBuf[7];
        end
        else if (sclFall)
        begin
            if (trs & (bitCnt != 4'h0) & (bitCnt < ACK_CNT))
            begin
                txShift <= {txShift[6:0], 1'b0};
                sdaLow <= ~txShift[6];
            end
            else
                sdaLow <= (bitCnt == ACK_CNT) & ackReq & ~trs;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaLow;

    ////////////////////////////////////////////////////////////////////////////
    // Master flags: progress, acknowledge result, collision
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trs <= 1'b0;
            ack <= 1'b0;
            bus_collision_flag <= 1'b0;
        end
        else if (~on)
        begin
            trs <= 1'b0;
            ack <= 1'b0;
            bus_collision_flag <= 1'b0;
        end
        else
        begin
            if (mStart)
                trs <= 1'b1;
            else if (collide | (ackEnd & trs) | stopDet)
                trs <= 1'b0;
            if (ackEnd & trs)
                ack <= ackSample;
            if (collide)
                bus_collision_flag <= 1'b1;
        end
    end

    // Slave address tracking
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            slvState <= SL_IDLE;
        else if (~on | stopDet)
            slvState <= SL_IDLE;
        else if (startDet)
            slvState <= SL_ADDR;
        else if (byteDone & ~trs)
        begin
            if (addrHit | tenHit)
                slvState <= SL_DATA;
            else if ((slvState == SL_ADDR) & hdrMatch)
                slvState <= SL_ADDR2;
            else if (slvState != SL_DATA)
                slvState <= SL_IDLE;
        end
    end

    // Slave-side flags; stop wipes general call and ten-bit match
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {gc, a10, da, rw, ackReq, pFlag, sFlag} <= 7'h00;
        end
        else if (~on)
        begin
            {gc, a10, da, rw, ackReq, pFlag, sFlag} <= 7'h00;
        end
        else
        begin
            if (stopDet)
            begin
                gc <= 1'b0;
                a10 <= 1'b0;
                pFlag <= 1'b1;
                sFlag <= 1'b0;
            end
            else if (startDet)
            begin
                sFlag <= 1'b1;
                pFlag <= 1'b0;
            end
            if (byteDone & ~trs)
            begin
                ackReq <= addrHit | tenHit | ((slvState == SL_ADDR) & hdrMatch) | (slvRx & ~rx_buffer_full);
                if (addrHit)
                begin
                    gc <= isGc;
                    da <= 1'b0;
                    rw <= isGc ? 1'b0 : byteIn[0];
                end
                else if (tenHit)
                begin
                    a10 <= 1'b1;
                    da <= 1'b0;
                end
                else if (slvRx)
                    da <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffers, write collision and overflow; hardware set beats software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {tx_buffer_full, rx_buffer_full, iwc, ov} <= 4'h0;
            txBuf <= 8'h00;
            rxBuf <= 8'h00;
        end
        else if (~on)
            {tx_buffer_full, rx_buffer_full, iwc, ov} <= 4'h0;
        else
        begin
            if (wrTx & ~busy)
            begin
                txBuf <= writedata[7:0];
                tx_buffer_full <= 1'b1;
            end
            else if (mStart)
                tx_buffer_full <= 1'b0;
            if (wrTx & busy)
                iwc <= 1'b1;
            else if (wrStat & writedata[IWC_BIT])
                iwc <= 1'b0;
            if (byteDone & slvRx & rx_buffer_full)
                ov <= 1'b1;
            else if (wrStat & writedata[OV_BIT])
                ov <= 1'b0;
            if (byteDone & slvRx & ~rx_buffer_full)
            begin
                rxBuf <= byteIn;
                rx_buffer_full <= 1'b1;
            end
            else if (rdRx)
                rx_buffer_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, own address, interrupt registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CTRL_RST;
            ownAddr <= OWNA_RST;
            irqStat <= '0;
            irqMask <= '0;
        end
        else
        begin
            if (wrCtrl)
                ctrl <= writedata[2:0];
            if (wrOwn)
                ownAddr <= writedata[9:0];
            if (wrIrqM)
                irqMask <= writedata[EV_W-1:0];
            irqStat <= events | (irqStat & ~(wrIrqS ? writedata[EV_W-1:0] : '0));
        end
    end

    assign irq = |(irqStat & irqMask);

    // Status word; unlisted positions stay zero
    always_comb
    begin
        statusWord = 32'h0;
        statusWord[ACK_BIT] = ack;
        statusWord[TRS_BIT] = trs;
        statusWord[BCL_BIT] = bus_collision_flag;
        statusWord[GC_BIT] = gc;
        statusWord[A10_BIT] = a10;
        statusWord[IWC_BIT] = iwc;
        statusWord[OV_BIT] = ov;
        statusWord[DA_BIT] = da;
        statusWord[P_BIT] = pFlag;
        statusWord[S_BIT] = sFlag;
        statusWord[RW_BIT] = rw;
        statusWord[RBF_BIT] = rx_buffer_full;
        statusWord[TBF_BIT] = tx_buffer_full;
    end

    assign readMux = (address == CTRL_OFS) ? {29'h0, ctrl} :
                     (address == STAT_OFS) ? statusWord :
                     (address == TXB_OFS) ? {24'h0, txBuf} :
                     (address == RXB_OFS) ? {24'h0, rxBuf} :
                     (address == OWNA_OFS) ? {22'h0, ownAddr} :
                     (address == IRQS_OFS) ? {28'h0, irqStat} :
                     (address == IRQM_OFS) ? {28'h0, irqMask} : 32'h0;

    // Reads take one wait cycle so read data comes from a flop
    assign waitrequest = read & ~rdDone;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdDone <= 1'b0;
            readdata <= 32'h0;
        end
        else
        begin
            rdDone <= read & ~rdDone;
            if (read & ~rdDone)
                readdata <= readMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_ack_update;
        @(posedge clk) disable iff (rst) (ackEnd && trs) |=> (ack == $past(ackSample));
    endproperty
    a_ack_update: assert property (p_ack_update) else $error("ack flag not updated");
    property p_trs_start;
        @(posedge clk) disable iff (rst) mStart |=> (trs && !tx_buffer_full);
    endproperty
    a_trs_start: assert property (p_trs_start) else $error("transmit progress not set");
    property p_trs_end;
        @(posedge clk) disable iff (rst) (ackEnd && trs) |=> !trs;
    endproperty
    a_trs_end: assert property (p_trs_end) else $error("transmit progress not cleared");
    property p_bcl_hold;
        @(posedge clk) disable iff (rst) (bus_collision_flag && on) |=> bus_collision_flag;
    endproperty
    a_bcl_hold: assert property (p_bcl_hold) else $error("collision flag lost while on");
    property p_stop_clear;
        @(posedge clk) disable iff (rst) stopDet |=> (!gc && !a10 && pFlag);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear flags");
    property p_tx_write_collision;
        @(posedge clk) disable iff (rst) (wrTx && busy && on) |=> (iwc && $stable(txBuf));
    endproperty
    a_tx_write_collision: assert property (p_tx_write_collision) else $error("write collision missed");
    property p_overflow;
        @(posedge clk) disable iff (rst) (byteDone && slvRx && rx_buffer_full) |=> (ov && $stable(rxBuf));
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed");
    property p_data_flag;
        @(posedge clk) disable iff (rst) (byteDone && slvRx) |=> da;
    endproperty
    a_data_flag: assert property (p_data_flag) else $error("data flag not set");
    property p_zero_bits;
        @(posedge clk) disable iff (rst) (readdata[31:16] == 16'h0) && (readdata[13:11] == 3'h0);
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bits not zero");
    property p_start_flag;
        @(posedge clk) disable iff (rst) startDet |=> (sFlag && !pFlag);
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start flag wrong");
endmodule : i2c_status_flags

// >>> test/i2c_bus_model.sv
// Far-side bus party: drives the serial clock and an open-drain data line
module i2c_bus_model (
    output logic scl,
    output logic sdaW,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    timeunit 1ns;
    timeprecision 1ns;

    logic sdaDrv;

    // Wire level: pulled up unless either party pulls it low
    assign sdaW = sdaDrv & (sdaOe ? sdaOut : 1'b1);

    // Clock stands high outside frames, data released
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One bit cell of 320 ns; data moves only while the clock is low,
    // and the low half is long enough for the synchroniser delay
    task automatic bitx(input logic b, output logic s);
        sdaDrv = b;
        #160;
        scl = 1'b1;
        #80;
        s = sdaW;
        #80;
        scl = 1'b0;
    endtask : bitx

    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ackDrv, output logic [7:0] got, output logic ackSeen);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], got[i]);
        bitx(ackDrv, ackSeen);
        sdaDrv = 1'b1;
        #160;
    endtask : xbyte

    // Data falls while the clock is high
    task automatic start();
        sdaDrv = 1'b1;
        scl = 1'b1;
        #160;
        sdaDrv = 1'b0;
        #160;
        scl = 1'b0;
        #160;
    endtask : start

    // Data rises while the clock is high; bus idle afterwards
    task automatic stop();
        sdaDrv = 1'b0;
        #160;
        scl = 1'b1;
        #160;
        sdaDrv = 1'b1;
        #160;
    endtask : stop

    // Lead-in clock fall that lets the device launch a master byte
    task automatic fall();
        scl = 1'b0;
        #160;
    endtask : fall
endmodule : i2c_bus_model

// >>> test/tb_i2c_status_flags.sv
module tb_i2c_status_flags
    import i2c_status_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, read, write, waitrequest, sdaOut, sdaOe, irq, scl, sdaW, ackSeen;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q, rnd;
    logic [7:0] got, d0;
    logic [6:0] own7;
    logic [9:0] a10;
    int errorCnt, compares;

    i2c_status_flags i_i2c_status_flags (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sclIn(scl), .sdaIn(sdaW),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
    i2c_bus_model i_i2c_bus_model (.scl(scl), .sdaW(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe));

    // 25 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] fl(input int p);
        return 32'h1 << p;
    endfunction : fl

    task automatic conclude();
        if (errorCnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One Avalon transfer; an extra edge first keeps strobes from being reassigned in one step
    task automatic bus(input logic [4:0] a, input logic rd, input logic [31:0] d, output logic [31:0] rq);
        int n;
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= ~rd;
        writedata <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        // Only a wait that never ended counts, not one that ended on the last edge
        if (waitrequest !== 1'b0)
        begin
            errorCnt++;
            conclude();
        end
        rq = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(a, 1'b0, d, dummy);
    endtask : wr

    // Status read; unimplemented positions are checked on every read
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        bus(STAT_OFS, 1'b1, 32'h0, q);
        chk(q & 32'hffff3800, 32'h0);
        chk(q & m, e);
    endtask : stat

    // Interrupt level looked at away from the clock edge
    task automatic irqChk(input logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irqChk

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        rnd = 32'hdcf9;
        errorCnt = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        stat(32'hffffffff, 32'h0);
        // Unmapped write must leave the status word clear, and the unmapped location reads back zero
        wr(5'h1c, 32'hffffffff);
        bus(5'h1c, 1'b1, 32'h0, q);
        chk(q, 32'h0);
        stat(32'hffffffff, 32'h0);
        // Slave receive, overflow and interrupt path
        rnd = lfsr(rnd);
        own7 = {1'b0, rnd[5:1], 1'b1};
        d0 = rnd[15:8];
        wr(OWNA_OFS, {25'h0, own7});
        wr(IRQM_OFS, fl(EV_RX));
        wr(CTRL_OFS, fl(ON_BIT));
        i_i2c_bus_model.start();
        i_i2c_bus_model.xbyte({own7, 1'b0}, 1'b1, got, ackSeen);
        chk({31'h0, ackSeen}, 32'h0);
        stat(fl(DA_BIT) | fl(S_BIT) | fl(P_BIT) | fl(RW_BIT), fl(S_BIT));
        i_i2c_bus_model.xbyte(d0, 1'b1, got, ackSeen);
        chk({31'h0, ackSeen}, 32'h0);
        irqChk(1'b1);
        stat(fl(DA_BIT) | fl(RBF_BIT), fl(DA_BIT) | fl(RBF_BIT));
        i_i2c_bus_model.xbyte(~d0, 1'b1, got, ackSeen);
        chk({31'h0, ackSeen}, 32'h1);
        stat(fl(OV_BIT), fl(OV_BIT));
        wr(IRQS_OFS, fl(EV_RX));
        irqChk(1'b0);
        bus(RXB_OFS, 1'b1, 32'h0, q);
        chk(q & 32'hff, {24'h0, d0});
        stat(fl(RBF_BIT), 32'h0);
        wr(STAT_OFS, fl(OV_BIT));
        stat(fl(OV_BIT), 32'h0);
        wr(IRQM_OFS, 32'h0);
        i_i2c_bus_model.stop();
        stat(fl(P_BIT) | fl(S_BIT), fl(P_BIT));
        bus(IRQS_OFS, 1'b1, 32'h0, q);
        chk(q & fl(EV_STOP), fl(EV_STOP));
        irqChk(1'b0);
        wr(IRQM_OFS, fl(EV_STOP));
        irqChk(1'b1);
        wr(IRQS_OFS, 32'h1f);
        irqChk(1'b0);
        // General call address, cleared by the stop
        i_i2c_bus_model.start();
        i_i2c_bus_model.xbyte(GENCALL_ADDR, 1'b1, got, ackSeen);
        chk({31'h0, ackSeen}, 32'h0);
        stat(fl(GC_BIT), fl(GC_BIT));
        i_i2c_bus_model.stop();
        stat(fl(GC_BIT), 32'h0);
        // Ten-bit address: flag only after the second byte
        a10 = rnd[25:16];
        wr(OWNA_OFS, {22'h0, a10});
        wr(CTRL_OFS, fl(ON_BIT) | fl(TEN_BIT));
        i_i2c_bus_model.start();
        i_i2c_bus_model.xbyte({TEN_HDR, a10[9:8], 1'b0}, 1'b1, got, ackSeen);
        stat(fl(A10_BIT), 32'h0);
        i_i2c_bus_model.xbyte(a10[7:0], 1'b1, got, ackSeen);
        chk({31'h0, ackSeen}, 32'h0);
        stat(fl(A10_BIT) | fl(DA_BIT), fl(A10_BIT));
        i_i2c_bus_model.stop();
        stat(fl(A10_BIT), 32'h0);
        // Master transmit, acknowledged then refused; a write while busy is dropped
        wr(CTRL_OFS, fl(ON_BIT) | fl(MST_BIT));
        for (int k = 0; k < 2; k++)
        begin
            rnd = lfsr(rnd);
            wr(TXB_OFS, {24'h0, rnd[7:0]});
            stat(fl(TBF_BIT) | fl(TRS_BIT), fl(TBF_BIT));
            wr(TXB_OFS, {24'h0, ~rnd[7:0]});
            stat(fl(IWC_BIT), fl(IWC_BIT));
            wr(STAT_OFS, fl(IWC_BIT));
            stat(fl(IWC_BIT), 32'h0);
            fork
                begin
                    i_i2c_bus_model.fall();
                    i_i2c_bus_model.xbyte(8'hff, k[0], got, ackSeen);
                end
                begin
                    repeat (40) @(posedge clk);
                    stat(fl(TRS_BIT) | fl(TBF_BIT), fl(TRS_BIT));
                end
            join
            chk({24'h0, got}, {24'h0, rnd[7:0]});
            stat(fl(TRS_BIT) | fl(ACK_BIT), k[0] ? fl(ACK_BIT) : 32'h0);
            i_i2c_bus_model.stop();
        end
        bus(IRQS_OFS, 1'b1, 32'h0, q);
        chk(q & fl(EV_TXDONE), fl(EV_TXDONE));
        // Collision: only switching the module off clears it
        wr(TXB_OFS, 32'h80);
        i_i2c_bus_model.fall();
        i_i2c_bus_model.bitx(1'b0, ackSeen);
        i_i2c_bus_model.stop();
        stat(fl(BCL_BIT) | fl(TRS_BIT), fl(BCL_BIT));
        wr(STAT_OFS, 32'hffffffff);
        stat(fl(BCL_BIT), fl(BCL_BIT));
        wr(CTRL_OFS, 32'h0);
        wr(CTRL_OFS, fl(ON_BIT) | fl(MST_BIT));
        stat(fl(BCL_BIT), 32'h0);
        // Reset in mid-run: module must come back off with flags clear
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        bus(CTRL_OFS, 1'b1, 32'h0, q);
        chk(q, {29'h0, CTRL_RST});
        stat(32'hffffffff, 32'h0);
        conclude();
    end
endmodule : tb_i2c_status_flags
